//--- sim/gpp_pad_model.sv
// Behavioural model of the pads and board wiring around the port.
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_model (
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_drv,
    output logic      [7:0] pad_in
);
    logic [7:0] held_q = 8'h00;
    logic [7:0] driven;

    // A pad nobody drives or pulls shows the inverse of its last driven
    // level, so a stale value can never pass for a real reading.
    assign driven = pad_oe | ext_drv | pad_pullup;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i] ? ext_val[i] :
                        pad_pullup[i] ? 1'b1 : ~held_q[i];
        end
    end
    always_ff @(posedge clk) begin
        held_q <= (driven & pad_in) | (~driven & held_q);
    end
endmodule
`default_nettype wire

//--- sim/gpp_port_tb.sv
// Self-checking bench for the GPIO pad port, driven over APB.
`timescale 1ns/1ns
`default_nettype none
module gpp_port_tb
    import gpp_pkg::*;
;
    typedef struct packed {
        logic        err;
        logic        rd;
        logic [31:0] data;
    } gpp_exp_t;
    gpp_exp_t    exp_q[$];
    gpp_exp_t    e;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_drv = 8'hff;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, wake, f;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup, pad_event;
    logic [7:0]  de, dv, m, op;
    logic [2:0]  codes[5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
    int          fails   = 0;
    int          n_tests = 0;

    always #5 clk_sys = ~clk_sys;

    gpp_port #(.FULL_ASYNC_PADS(8'h00)) DUT (
        .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
        .PAD_PULLUP(pad_pullup), .PAD_EVENT(pad_event), .IRQ(irq),
        .WAKE(wake));
    gpp_pad_model PADS (
        .clk(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_drv(ext_drv),
        .pad_in(pad_in));

    // ****************************************************************
    // Bus tasks and result checking
    // ****************************************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            fails++;
            $display("[FAIL] t=%0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, input logic [3:0] st,
                       input logic err, input logic [7:0] rd);
        int n;
        exp_q.push_back({err, ~w, 24'h000000, rd});
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, 32'(d), 4'h1, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] x);
        apb(1'b0, idx, 32'h0, 4'h0, 1'b0, x);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // The monitor pairs every completed transfer with the oldest note.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            check(32'(pslverr), 32'(e.err));
            if (e.rd) begin
                check(prdata, e.data);
            end
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(32'hb406bf1c));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            if (i < 10 || i > 15) begin
                rd(8'(i), 8'h00);
            end
        end
        apb(1'b0, 8'h0a, 32'h0, 4'h0, 1'b1, 8'h00);
        apb(1'b1, 8'h18, 32'hff, 4'h1, 1'b1, 8'h00);
        check(32'(pad_oe), 32'h0);
        $display("reset values done");
        de = 8'h00;
        for (int k = 0; k < 8; k++) begin
            m = 8'($urandom);
            op = 8'(k % 4);
            case (op)
                8'h00: de = m;
                8'h01: de = de | m;
                8'h02: de = de & ~m;
                default: de = de ^ m;
            endcase
            wr(GPP_IDX_DE + op, m);
            rd(GPP_IDX_DE + op, de);
            settle(2);
            check(32'(pad_oe), 32'(de));
        end
        $display("direction strobes done");
        dv = 8'h00;
        for (int k = 0; k < 10; k++) begin
            m = 8'($urandom);
            op = 8'(k % 5);
            ext_val <= 8'($urandom);
            case (op)
                8'h00: dv = m;
                8'h01: dv = dv | m;
                8'h02: dv = dv & ~m;
                default: dv = dv ^ m;
            endcase
            wr(op == 8'h04 ? GPP_IDX_LEVEL : GPP_IDX_DV + op, m);
            apb(1'b1, GPP_IDX_DV, 32'hff, 4'h0, 1'b0, 8'h00);
            rd(GPP_IDX_DV, dv);
            settle(4);
            check(32'(pad_out), 32'(dv & de));
            rd(GPP_IDX_LEVEL, (de & dv) | (~de & ext_val));
        end
        $display("drive value strobes done");
        ext_drv <= 8'hfe;
        wr(GPP_IDX_DE, 8'h00);
        wr(GPP_IDX_CFG0, 8'hf8);
        rd(GPP_IDX_CFG0, 8'h88);
        settle(4);
        check(32'(pad_pullup), 32'h01);
        rd(GPP_IDX_LEVEL, {ext_val[7:1], 1'b0});
        wr(GPP_IDX_DE, 8'h01);
        settle(4);
        check(32'(pad_out), {31'h0, ~dv[0]});
        rd(GPP_IDX_LEVEL, {ext_val[7:1], dv[0]});
        wr(GPP_IDX_DE, 8'h00);
        wr(GPP_IDX_CFG0, 8'h00);
        ext_drv <= 8'hff;
        $display("polarity and pull-up done");
        foreach (codes[j]) begin
            ext_val[1] <= 1'b1;
            settle(4);
            wr(GPP_IDX_CFG0 + 8'h01, {5'h00, codes[j]});
            wr(GPP_IDX_FLAGS, 8'hff);
            settle(4);
            check(32'({irq, pad_event[1]}),
                  32'({1'b0, codes[j] != 3'h4}));
            ext_val[1] <= 1'b0;
            settle(6);
            f = codes[j] inside {3'h1, 3'h3, 3'h5};
            check(32'({irq, wake}),
                  32'({f, codes[j] inside {3'h1, 3'h5}}));
            rd(GPP_IDX_FLAGS, {6'h00, f, 1'b0});
            wr(GPP_IDX_FLAGS, 8'h02);
            ext_val[1] <= 1'b1;
            settle(6);
            f = codes[j] inside {3'h1, 3'h2, 3'h5};
            rd(GPP_IDX_FLAGS, {6'h00, f, 1'b0});
        end
        $display("pad sensing done");
        give_verdict();
    end
endmodule
`default_nettype wire

//--- src/gpp_pkg.sv
// Package with register map, field layout and types of the GPIO pad port.
package gpp_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int GPP_PADS = 8;

    // ****************************************************************
    // Register indices; the byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] GPP_IDX_DE       = 8'h00;
    localparam logic [7:0] GPP_IDX_DE_SET   = 8'h01;
    localparam logic [7:0] GPP_IDX_DE_CLR   = 8'h02;
    localparam logic [7:0] GPP_IDX_DE_FLIP  = 8'h03;
    localparam logic [7:0] GPP_IDX_DV       = 8'h04;
    localparam logic [7:0] GPP_IDX_DV_SET   = 8'h05;
    localparam logic [7:0] GPP_IDX_DV_CLR   = 8'h06;
    localparam logic [7:0] GPP_IDX_DV_FLIP  = 8'h07;
    localparam logic [7:0] GPP_IDX_LEVEL    = 8'h08;
    localparam logic [7:0] GPP_IDX_FLAGS    = 8'h09;
    localparam logic [7:0] GPP_IDX_CFG0     = 8'h10;
    localparam logic [7:0] GPP_IDX_CFG_LAST = 8'h17;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] GPP_RST_DE    = 8'h00;
    localparam logic [7:0] GPP_RST_DV    = 8'h00;
    localparam logic [7:0] GPP_RST_FLAGS = 8'h00;

    // ****************************************************************
    // Sense codes held in per_pad_config bits 2:0
    // ****************************************************************
    localparam logic [2:0] GPP_SENSE_NOIRQ    = 3'h0;
    localparam logic [2:0] GPP_SENSE_ANY_EDGE = 3'h1;
    localparam logic [2:0] GPP_SENSE_RISING   = 3'h2;
    localparam logic [2:0] GPP_SENSE_FALLING  = 3'h3;
    localparam logic [2:0] GPP_SENSE_OFF      = 3'h4;
    localparam logic [2:0] GPP_SENSE_LOW      = 3'h5;

    // Bits 6:4 of per_pad_config are reserved and read as zero.
    typedef struct packed {
        logic       polarity_flip;   // Bit 7.
        logic [2:0] unused;          // Bits 6:4.
        logic       weak_high_bias;  // Bit 3.
        logic [2:0] sense_config;    // Bits 2:0.
    } gpp_cfg_t;

    localparam gpp_cfg_t GPP_RST_CFG = '0;

endpackage

//--- src/gpp_port.sv
// GPIO pad port with APB register access, sensing, events and wake-up.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - One port handles eight pads; bit n of enable and value governs pad n.
// - A one in drive_enable bit n turns pad n into a driven output.
// - Set strobe for drive_enable sets chosen bits only.
// - Clear strobe for drive_enable clears chosen bits only.
// - Flip strobe for drive_enable inverts chosen bits, reversing direction.
// - Set strobe for drive value sets chosen bits; zeros do nothing.
// - Clear strobe for drive value clears chosen bits only.
// - Writing ones to flip strobe or level register inverts drive value bits.
// - Each pad level is synchronised to the main clock, then readable.
// - Sense off freezes the pad synchroniser; its level bit is stale.
// - Pad level stays readable whether the pad is input or output.
// - After reset outputs are tri-stated and inputs enabled.
// - Pad n configuration sits at index 0x10 plus n.
// - Polarity flip inverts both input and output paths of the pad.
// - Changing polarity flip makes an edge that sensing and events see.
// - Weak high bias bit enables the pad pull-up.
// - Interrupt sensing on any edge, rising, falling or low level.
// - Flip and sense change together may lose the flip edge.
// - Pending sense across input disable may fire on re-enable.
// - Sense change during synchronisation may drop the interrupt.
// - Async pads wake for every interrupt sense; others for any edge or level.
// - Async sensing can wake the device with no clock running; here WAKE is a flop on CLK_SYS fed from flags_q, so it needs the clock.
// - Drive value sets pad level only while the pad is enabled.
// - Reading drive_enable strobes returns the drive_enable value.
// - Interrupt stands while source enabled and flag set, until cleared.
// - Event output follows pad value with input on, zero when off.
module gpp_port
    import gpp_pkg::*;
#(
    parameter logic [7:0] FULL_ASYNC_PADS = 8'h00
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  PAD_IN,
    output logic      [7:0]  PAD_OUT,
    output logic      [7:0]  PAD_OE,
    output logic      [7:0]  PAD_PULLUP,
    output logic      [7:0]  PAD_EVENT,
    output logic             IRQ,
    output logic             WAKE
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [7:0]  de_q;
    logic [7:0]  dv_q;
    logic [7:0]  flags_q;
    logic [7:0]  sync1_q;
    logic [7:0]  sync2_q;
    logic [7:0]  prev_q;
    gpp_cfg_t    cfg_q [GPP_PADS];
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;

    wire logic [7:0] idx      = PADDR[9:2];
    wire logic       in_range = (PADDR[11:10] == 2'h0)
                              && (PADDR[1:0] == 2'h0);
    wire logic       is_cfg   = (idx >= GPP_IDX_CFG0)
                              && (idx <= GPP_IDX_CFG_LAST);
    wire logic       mapped   = in_range
                              && ((idx <= GPP_IDX_FLAGS) || is_cfg);
    wire logic       setup    = PSEL && !PENABLE;
    wire logic       wr       = PSEL && PENABLE && PWRITE && pready_q
                              && mapped && PSTRB[0];
    wire logic [7:0] d        = PWDATA[7:0];

    wire logic wr_de    = wr && (idx == GPP_IDX_DE);
    wire logic wr_des   = wr && (idx == GPP_IDX_DE_SET);
    wire logic wr_dec   = wr && (idx == GPP_IDX_DE_CLR);
    wire logic wr_def   = wr && (idx == GPP_IDX_DE_FLIP);
    wire logic wr_dv    = wr && (idx == GPP_IDX_DV);
    wire logic wr_dvs   = wr && (idx == GPP_IDX_DV_SET);
    wire logic wr_dvc   = wr && (idx == GPP_IDX_DV_CLR);
    wire logic wr_dvf   = wr && ((idx == GPP_IDX_DV_FLIP)
                              || (idx == GPP_IDX_LEVEL));
    wire logic wr_flags = wr && (idx == GPP_IDX_FLAGS);

    // ****************************************************************
    // Direction and drive value
    // ****************************************************************
    wire logic [7:0] de_d = wr_de  ? d
                          : wr_des ? (de_q | d)
                          : wr_dec ? (de_q & ~d)
                          : wr_def ? (de_q ^ d)
                          : de_q;
    wire logic [7:0] dv_d = wr_dv  ? d
                          : wr_dvs ? (dv_q | d)
                          : wr_dvc ? (dv_q & ~d)
                          : wr_dvf ? (dv_q ^ d)
                          : dv_q;

    // ****************************************************************
    // Per-pad sensing
    // ****************************************************************
    logic [7:0] lvl;
    logic [7:0] sense_on;
    logic [7:0] ev;
    logic [7:0] irq_en;
    logic [7:0] wake_en;
    logic [7:0] flip;
    logic [7:0] bias;

    genvar n;
    generate
        for (n = 0; n < GPP_PADS; n++) begin : g_pad
            wire logic [2:0] s = cfg_q[n].sense_config;
            assign flip[n]     = cfg_q[n].polarity_flip;
            assign bias[n]     = cfg_q[n].weak_high_bias;
            assign sense_on[n] = (s != GPP_SENSE_OFF);
            assign lvl[n]      = sync2_q[n] ^ flip[n];
            assign irq_en[n]   = (s == GPP_SENSE_ANY_EDGE)
                               || (s == GPP_SENSE_RISING)
                               || (s == GPP_SENSE_FALLING)
                               || (s == GPP_SENSE_LOW);
            // Rising and falling sense need a running clock to compare
            // samples, so only fully asynchronous pads may wake on them.
            assign wake_en[n]  = FULL_ASYNC_PADS[n] ? irq_en[n]
                               : ((s == GPP_SENSE_ANY_EDGE)
                               || (s == GPP_SENSE_LOW));
            assign ev[n] = (s == GPP_SENSE_ANY_EDGE) ? (lvl[n] ^ prev_q[n])
                         : (s == GPP_SENSE_RISING)
                           ? (lvl[n] & ~prev_q[n])
                         : (s == GPP_SENSE_FALLING)
                           ? (~lvl[n] & prev_q[n])
                         : (s == GPP_SENSE_LOW) ? ~lvl[n]
                         : 1'b0;

            // The clock cannot be gated here, so a disabled pad simply
            // holds its synchroniser; the stale value is the price paid.
            always_ff @(posedge CLK_SYS) begin
                if (RST) begin
                    sync1_q[n] <= 1'b0;
                    sync2_q[n] <= 1'b0;
                end else if (sense_on[n]) begin
                    sync1_q[n] <= PAD_IN[n];
                    sync2_q[n] <= sync1_q[n];
                end
            end

            always_ff @(posedge CLK_SYS) begin
                if (RST) begin
                    cfg_q[n] <= GPP_RST_CFG;
                end else if (wr && (idx == GPP_IDX_CFG0
                             + 8'(n))) begin
                    cfg_q[n] <= gpp_cfg_t'({d[7], 3'h0, d[3], d[2:0]});
                end
            end
        end
    endgenerate

    // Hardware set wins over a software clear in the same cycle.
    wire logic [7:0] flags_d = (flags_q & ~(wr_flags ? d : 8'h00))
                             | ev;

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire logic [7:0] cfg_rd = cfg_q[idx[2:0]];
    wire logic [7:0] rd_byte =
        !mapped                    ? 8'h00
      : (idx <= GPP_IDX_DE_FLIP)   ? de_q
      : (idx <= GPP_IDX_DV_FLIP)   ? dv_q
      : (idx == GPP_IDX_LEVEL)     ? lvl
      : (idx == GPP_IDX_FLAGS)     ? flags_q
      : cfg_rd;

    // ****************************************************************
    // State and outputs
    // ****************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            de_q <= GPP_RST_DE;
        end else begin
            de_q <= de_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            dv_q <= GPP_RST_DV;
        end else begin
            dv_q <= dv_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            flags_q <= GPP_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= lvl;
        end
    end

    // No wait state: the setup cycle prepares the answer so that all
    // bus outputs come from flip-flops.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup && !mapped;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    logic [7:0] pad_out_q;
    logic [7:0] pad_oe_q;
    logic [7:0] pad_pull_q;
    logic [7:0] pad_event_q;
    logic       irq_q;
    logic       wake_q;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pad_out_q <= 8'h00;
        end else begin
            pad_out_q <= (dv_q ^ flip) & de_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pad_oe_q <= 8'h00;
        end else begin
            pad_oe_q <= de_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pad_pull_q <= 8'h00;
        end else begin
            pad_pull_q <= bias;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pad_event_q <= 8'h00;
        end else begin
            pad_event_q <= lvl & sense_on;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & irq_en);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= |(flags_q & wake_en);
        end
    end

    assign PRDATA     = prdata_q;
    assign PREADY     = pready_q;
    assign PSLVERR    = pslverr_q;
    assign PAD_OUT    = pad_out_q;
    assign PAD_OE     = pad_oe_q;
    assign PAD_PULLUP = pad_pull_q;
    assign PAD_EVENT  = pad_event_q;
    assign IRQ        = irq_q;
    assign WAKE       = wake_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_dir_set_bits: assert property (wr_des |=> de_q == ($past(de_q)
        | $past(d))) else $error("drive enable set failed");
    a_dir_clr_bits: assert property (wr_dec |=> de_q == ($past(de_q)
        & ~$past(d))) else $error("drive enable clear failed");
    a_dir_flip_bits: assert property (wr_def |=> de_q == ($past(de_q)
        ^ $past(d))) else $error("drive enable flip failed");
    a_out_set_bits: assert property (wr_dvs |=> dv_q == ($past(dv_q)
        | $past(d))) else $error("drive value set failed");
    a_out_clr_bits: assert property (wr_dvc |=> dv_q == ($past(dv_q)
        & ~$past(d))) else $error("drive value clear failed");
    a_out_flip_bits: assert property (wr_dvf |=> dv_q == ($past(dv_q)
        ^ $past(d))) else $error("drive value flip failed");
    a_oe_from_write: assert property (wr_des && d[0] |-> ##2 PAD_OE[0])
        else $error("pad did not become output");
    a_strobe_reads: assert property (setup && in_range
        && idx == GPP_IDX_DE_SET |=> PRDATA[7:0] == $past(de_q))
        else $error("strobe read not drive enable");
    a_pad_sync: assert property (sense_on[0] && !flip[0]
        && cfg_q[0] == $past(cfg_q[0]) ##1 $stable(cfg_q[0])
        |-> lvl[0] == $past(PAD_IN[0], 2))
        else $error("pad level not synchronised");
    a_irq_holds: assert property ((|(flags_q & irq_en)) |=> IRQ)
        else $error("interrupt not asserted");
    a_event_off: assert property (!sense_on[1] |=> !PAD_EVENT[1])
        else $error("event not zero with input off");
    a_ready_once: assert property (setup |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle");
    a_reset_tristate: assert property (disable iff (1'b0) RST
        |=> PAD_OE == 8'h00 && !IRQ && !PREADY)
        else $error("outputs active after reset");
    a_pslverr_map: assert property (setup && !mapped
        |=> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_pull_follows: assert property (1'b1 |=> PAD_PULLUP == $past(bias))
        else $error("pull-up not following config");
    a_out_masked: assert property ((PAD_OUT & ~PAD_OE) == 8'h00)
        else $error("value driven on disabled pad");
    a_out_polarity: assert property (flip[0] && de_q[0]
        |=> PAD_OUT[0] == !$past(dv_q[0]))
        else $error("output not inverted");
    a_flip_edge: assert property (!$stable(flip[0])
        && $stable(sync2_q[0]) |-> lvl[0] != $past(lvl[0]))
        else $error("polarity change made no edge");
    a_flag_clear: assert property (wr_flags
        |=> (flags_q & $past(d) & ~$past(ev)) == 8'h00)
        else $error("flag not cleared by write");
    a_sync_frozen: assert property (!sense_on[1] |=> $stable(sync2_q[1]))
        else $error("synchroniser ran with sense off");
    a_wake_gate: assert property ((flags_q & wake_en) == 8'h00 |=> !WAKE)
        else $error("wake without capable flag");

    c_irq_raised: cover property (!IRQ ##1 IRQ);
    c_flip_write: cover property (wr_dvf && |d);
    c_unmapped:   cover property (PSLVERR);
    c_low_sense:  cover property (cfg_q[1].sense_config == GPP_SENSE_LOW
        && flags_q[1]);
    c_back2back:  cover property (PREADY && setup);

endmodule

`default_nettype wire
